// file: src/ext_bus_pkg.sv
// Constants and carrier types for the multiplexed external memory bus.
package ext_bus_pkg;

    // Cycle lengths in oscillator periods, one period per clock.
    localparam int FETCH_PERIODS = 3;
    localparam int DATA_PERIODS  = 6;
    // Strobe-low lengths derived from the cycle lengths.
    localparam int FETCH_STROBE  = FETCH_PERIODS - 1;
    localparam int READ_STROBE   = DATA_PERIODS - 3;
    localparam int WRITE_STROBE  = DATA_PERIODS - 4;
    localparam int TIMER_W       = 2;

    // Highest program address served by internal program memory.
    localparam logic [15:0] INT_CODE_TOP   = 16'h3FFF;
    // Value forced into the port 0 latch on an external access.
    localparam logic [7:0]  P0_LATCH_FILL  = 8'h00FF;
    // Latch pulse gate after reset: generation enabled.
    localparam logic        GATE_RST       = 1'b1;

    typedef enum logic [2:0] {
        ACC_FETCH  = 3'b001,
        ACC_DREAD  = 3'b010,
        ACC_DWRITE = 3'b100
    } access_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ALE  = 5'b00010,
        ST_ADDR = 5'b00100,
        ST_STRB = 5'b01000,
        ST_HOLD = 5'b10000
    } state_e;

    typedef struct packed {
        access_e     kind;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } req_s;

    typedef struct packed {
        logic        ale;
        logic        program_store_strobe_n;
        logic        rd_n;
        logic        wr_n;
        logic [7:0]  p0_o;
        logic        p0_oe;
        logic [7:0]  p2_o;
        logic [7:0]  p2_strong;
        logic        p2_bus_sel;
    } pins_s;

    typedef struct packed {
        logic        done;
        logic        external;
        logic [7:0]  rdata;
    } resp_s;

    localparam pins_s PINS_RST = '{
        ale: 1'b0, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
        p0_o: 8'h0000, p0_oe: 1'b0, p2_o: 8'h00FF, p2_strong: 8'h0000,
        p2_bus_sel: 1'b0};

endpackage

// file: src/strobe_timer.sv
// Down counter that times the strobe-low phase of a bus cycle.
`timescale 1ns/100ps
module strobe_timer #(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         sys_clk_i,
    input  wire logic         rst_b_i,
    // Load and expiry.
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              zero_o
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    assign count_nxt = load_i ? value_i :
                       (count_r != '0) ? count_r - 1'b1 : count_r;
    assign zero_o    = (count_r == '0);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule // strobe_timer

// file: src/ext_bus_if.sv
// Multiplexed external program and data memory bus interface.
`timescale 1ns/100ps

// Behaviour
// - Cleared latch pulse gate stops the address latch pulse of fetches while access select is high.
// - Program fetches use only the program store strobe as read strobe.
// - Data reads use the read strobe, data writes the write strobe.
// - External program fetches always put a 16-bit address out.
// - Data access is 16-bit through data pointer, 8-bit through register.
// - Port 0 carries low address then data, detached from its latch.
// - Port 0 drives both levels while it serves as the bus.
// - Every external access loads the port 0 latch with all ones.
// - High address byte holds on port 2 for whole cycle, latch untouched.
// - With 8-bit addresses port 2 keeps showing its latch contents.
// - Port 2 address ones get the strong pull-up for the whole cycle.
// - Write data is on port 0 before and after the write strobe.
// - Read byte is captured before the read strobe is released.
// - Fetch externally when access select is low or address above 3FFF.
// - Data read cycle lasts six periods, data write five, program fetch three.
// - Access select low forces the pulse; else the gate applies to fetches only, data always pulses.
// - After reset the latch pulse is enabled.
module ext_bus_if (
    // Clock and reset.
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_b_i,
    // Core request and answer.
    input  wire logic                 req_valid_i,
    input  wire ext_bus_pkg::req_s    req_i,
    output logic                      req_ready_o,
    output ext_bus_pkg::resp_s        resp_o,
    // System control and strap.
    input  wire logic                 gate_wr_i,
    input  wire logic                 gate_val_i,
    input  wire logic                 external_access_select_n_i,
    output logic                      latch_pulse_gate_o,
    // Port latches.
    input  wire logic [7:0]           p2_latch_i,
    output logic                      p0_latch_load_o,
    output logic [7:0]                p0_latch_data_o,
    // Bus pins.
    input  wire logic [7:0]           p0_i,
    output ext_bus_pkg::pins_s        pins_o
);

    ext_bus_pkg::state_e state_r;
    ext_bus_pkg::state_e state_nxt;
    ext_bus_pkg::req_s   req_r;
    ext_bus_pkg::pins_s  pins_nxt;
    ext_bus_pkg::resp_s  resp_nxt;
    logic                ext_r;
    logic                gate_r;
    logic                ready_r;
    logic                load_r;
    logic                take;
    logic                idle;
    logic                cur_ext;
    ext_bus_pkg::req_s   cur_req;
    logic [7:0]          fill_r;
    logic                ext_take;
    logic                is_fetch;
    logic                is_read;
    logic                is_write;
    logic                timer_load;
    logic                timer_zero;
    logic                last_strb;
    logic                capture;
    logic                on_bus;
    logic                ale_allowed;
    logic                p2_addr_sel;
    logic [7:0]          p2_value;
    logic [ext_bus_pkg::TIMER_W-1:0] strobe_len;

    function automatic logic [ext_bus_pkg::TIMER_W-1:0] len_m1(input int n);
        len_m1 = ext_bus_pkg::TIMER_W'(n - 1);
    endfunction

    assign take     = req_valid_i && ready_r;
    // The request being taken already shapes the pins of the first cycle.
    assign idle     = (state_r == ext_bus_pkg::ST_IDLE);
    assign cur_req  = idle ? req_i : req_r;
    assign cur_ext  = idle ? ext_take : ext_r;
    assign is_fetch = (cur_req.kind == ext_bus_pkg::ACC_FETCH);
    assign is_read  = (cur_req.kind == ext_bus_pkg::ACC_DREAD);
    assign is_write = (cur_req.kind == ext_bus_pkg::ACC_DWRITE);

    // Data moves are always external; fetches when access select is low or above internal code.
    assign ext_take = (req_i.kind != ext_bus_pkg::ACC_FETCH) ||
                      !external_access_select_n_i ||
                      (req_i.addr > ext_bus_pkg::INT_CODE_TOP);

    // Strobe phase length per access kind.
    assign strobe_len = is_fetch ? len_m1(ext_bus_pkg::FETCH_STROBE) :
                        is_read  ? len_m1(ext_bus_pkg::READ_STROBE)  :
                                   len_m1(ext_bus_pkg::WRITE_STROBE);

    assign last_strb  = (state_r == ext_bus_pkg::ST_STRB) && timer_zero;
    assign timer_load = (state_nxt == ext_bus_pkg::ST_STRB) &&
                        (state_r != ext_bus_pkg::ST_STRB);
    assign capture    = last_strb && ext_r && !is_write;

    // Fetch: latch, two strobes. Data: latch, address, strobes, hold.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ext_bus_pkg::ST_IDLE: begin
                if (take) begin
                    state_nxt = ext_bus_pkg::ST_ALE;
                end
            end
            ext_bus_pkg::ST_ALE: begin
                state_nxt = is_fetch ? ext_bus_pkg::ST_STRB :
                                       ext_bus_pkg::ST_ADDR;
            end
            ext_bus_pkg::ST_ADDR: begin
                state_nxt = ext_bus_pkg::ST_STRB;
            end
            ext_bus_pkg::ST_STRB: begin
                if (timer_zero) begin
                    state_nxt = is_fetch ? ext_bus_pkg::ST_IDLE :
                                           ext_bus_pkg::ST_HOLD;
                end
            end
            ext_bus_pkg::ST_HOLD: begin
                state_nxt = ext_bus_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = ext_bus_pkg::ST_IDLE;
            end
        endcase
    end

    // Pin values belonging to the next state, registered below.
    assign on_bus      = (state_nxt != ext_bus_pkg::ST_IDLE) && cur_ext;
    assign ale_allowed = !external_access_select_n_i || gate_r ||
                         !is_fetch;
    assign p2_addr_sel = on_bus && (is_fetch || cur_req.wide);
    assign p2_value    = p2_addr_sel ? cur_req.addr[15:8] : p2_latch_i;

    always_comb begin
        pins_nxt = ext_bus_pkg::PINS_RST;
        pins_nxt.ale = (state_nxt == ext_bus_pkg::ST_ALE) &&
                       ale_allowed;
        pins_nxt.program_store_strobe_n =
            !(on_bus && is_fetch &&
              (state_nxt == ext_bus_pkg::ST_STRB));
        pins_nxt.rd_n = !(on_bus && is_read &&
                          (state_nxt == ext_bus_pkg::ST_STRB));
        pins_nxt.wr_n = !(on_bus && is_write &&
                          (state_nxt == ext_bus_pkg::ST_STRB));
        // Address on latch phase and on address phase of reads; write data from the address phase on.
        pins_nxt.p0_oe = on_bus &&
                         ((state_nxt == ext_bus_pkg::ST_ALE) ||
                          (state_nxt == ext_bus_pkg::ST_ADDR) ||
                          is_write);
        pins_nxt.p0_o  = (is_write && (state_nxt != ext_bus_pkg::ST_ALE)) ?
                         cur_req.wdata : cur_req.addr[7:0];
        pins_nxt.p2_o       = p2_value;
        pins_nxt.p2_strong  = on_bus ? p2_value : 8'h0000;
        pins_nxt.p2_bus_sel = p2_addr_sel;
    end

    always_comb begin
        resp_nxt          = resp_o;
        resp_nxt.done     = 1'b0;
        if (capture) begin
            resp_nxt.rdata = p0_i;
        end
        if ((state_r != ext_bus_pkg::ST_IDLE) &&
            (state_nxt == ext_bus_pkg::ST_IDLE)) begin
            resp_nxt.done     = 1'b1;
            resp_nxt.external = ext_r;
        end
    end

    strobe_timer #(
        .W (ext_bus_pkg::TIMER_W)
    ) u_strobe_timer (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .load_i    (timer_load),
        .value_i   (strobe_len),
        .zero_o    (timer_zero)
    );

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gate_r <= ext_bus_pkg::GATE_RST;
        end else if (gate_wr_i) begin
            gate_r <= gate_val_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ext_bus_pkg::ST_IDLE;
            ready_r <= 1'b0;
            req_r   <= '{kind: ext_bus_pkg::ACC_FETCH, wide: 1'b0,
                         addr: 16'h0000, wdata: 8'h0000};
            ext_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt == ext_bus_pkg::ST_IDLE) && !take;
            if (take) begin
                req_r <= req_i;
                ext_r <= ext_take;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_o <= ext_bus_pkg::PINS_RST;
            resp_o <= '{done: 1'b0, external: 1'b0, rdata: 8'h0000};
            load_r <= 1'b0;
            fill_r <= ext_bus_pkg::P0_LATCH_FILL;
        end else begin
            pins_o <= pins_nxt;
            resp_o <= resp_nxt;
            load_r <= take && ext_take;
            fill_r <= ext_bus_pkg::P0_LATCH_FILL;
        end
    end

    assign req_ready_o        = ready_r;
    assign latch_pulse_gate_o = gate_r;
    assign p0_latch_load_o    = load_r;
    assign p0_latch_data_o    = fill_r;

endmodule // ext_bus_if

// file: verification/ext_bus_assertions.sv
// Concurrent checks on the external memory bus pins and answers.
`timescale 1ns/100ps
module ext_bus_assertions (
    // Clock and reset.
    input wire logic               sys_clk_i,
    input wire logic               rst_b_i,
    // Watched ports.
    input wire ext_bus_pkg::resp_s resp_o,
    input wire logic [7:0]         p2_latch_i,
    input wire ext_bus_pkg::pins_s pins_o
);
    logic strb;
    assign strb = !pins_o.rd_n || !pins_o.wr_n
        || !pins_o.program_store_strobe_n;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_wr_setup;
        $fell(pins_o.wr_n) |-> $past(pins_o.p0_oe) && pins_o.p0_oe
            && $stable(pins_o.p0_o);
    endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("wr setup");
    property p_wr_hold;
        $rose(pins_o.wr_n) |-> pins_o.p0_oe && $stable(pins_o.p0_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("wr hold");
    property p_rd_release;
        !pins_o.rd_n |-> pins_o.wr_n && !pins_o.p0_oe;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("rd");
    property p_rd_len;
        $fell(pins_o.rd_n) |-> !pins_o.rd_n[*3] ##1 pins_o.rd_n;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("rd len");
    property p_fetch_len;
        $fell(pins_o.program_store_strobe_n) |->
            !pins_o.program_store_strobe_n[*2]
            ##1 (pins_o.program_store_strobe_n && resp_o.done);
    endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch");
    property p_data_cycle;
        $rose(pins_o.ale) ##1 (pins_o.p0_oe && pins_o.program_store_strobe_n)
            ##1 !pins_o.rd_n |-> ##4 resp_o.done;
    endproperty
    a_data_cycle: assert property (p_data_cycle) else $error("data");
    property p_wr_cycle;
        $fell(pins_o.wr_n) |-> !pins_o.wr_n[*2]
            ##1 (pins_o.wr_n && pins_o.p0_oe) ##1 resp_o.done;
    endproperty
    a_wr_cycle: assert property (p_wr_cycle) else $error("wr cycle");
    property p_p2_hold;
        strb && pins_o.p2_bus_sel |-> $stable(pins_o.p2_o)
            && pins_o.p2_strong == pins_o.p2_o;
    endproperty
    a_p2_hold: assert property (p_p2_hold) else $error("p2");
    property p_paging;
        strb && !pins_o.p2_bus_sel |-> pins_o.p2_o == p2_latch_i
            && pins_o.p2_strong == pins_o.p2_o;
    endproperty
    a_paging: assert property (p_paging) else $error("paging");
    c_rd: cover property ($fell(pins_o.rd_n));
    c_wr: cover property ($fell(pins_o.wr_n));
    c_fetch: cover property ($fell(pins_o.program_store_strobe_n));
endmodule // ext_bus_assertions

bind ext_bus_if ext_bus_assertions u_ext_bus_assertions (
    .sys_clk_i, .rst_b_i, .resp_o, .p2_latch_i, .pins_o);

// file: verification/ext_mem_model.sv
// Behavioural external memory with its address latch.
`timescale 1ns/100ps
module ext_mem_model (
    // Clock and bus pins.
    input  wire logic               sys_clk_i,
    input  wire ext_bus_pkg::pins_s pins_i,
    // Port 0 level and last written place.
    output logic [7:0]              bus_o,
    output logic [15:0]             wr_addr_o,
    output logic [7:0]              wr_data_o
);
    logic [7:0]  lo_r = 8'h00;
    logic [7:0]  last_r = 8'h00;
    logic [15:0] addr;
    logic        rd_on;
    assign addr = {pins_i.p2_o, lo_r};
    assign rd_on = !pins_i.rd_n || !pins_i.program_store_strobe_n;
    // Interface drives when enabled, memory during a read strobe, else the last bus level inverted.
    assign bus_o = pins_i.p0_oe ? pins_i.p0_o
        : rd_on ? (addr[7:0] ^ ~addr[15:8]) : ~last_r;
    always @(posedge sys_clk_i) last_r <= bus_o;
    always @(posedge sys_clk_i) begin
        if (pins_i.ale) begin
            lo_r <= pins_i.p0_o;
        end
    end
    always @(posedge sys_clk_i) begin
        if (!pins_i.wr_n) begin
            wr_addr_o <= addr;
            wr_data_o <= bus_o;
        end
    end
endmodule // ext_mem_model

// file: verification/tb_top.sv
// Self-checking bench for the external memory bus interface.
`timescale 1ns/100ps
module tb_top;
    logic                sys_clk_i;
    logic                rst_b_i;
    logic                req_valid_i;
    ext_bus_pkg::req_s   req_i;
    logic                req_ready_o;
    ext_bus_pkg::resp_s  resp_o;
    logic                gate_wr_i;
    logic                gate_val_i;
    logic                external_access_select_n_i;
    logic                latch_pulse_gate_o;
    logic [7:0]          p2_latch_i;
    logic                p0_latch_load_o;
    logic [7:0]          p0_latch_data_o;
    logic [7:0]          p0_i;
    ext_bus_pkg::pins_s  pins_o;
    logic [15:0]         wr_addr;
    logic [7:0]          wr_data;
    logic [4:0]          seen;
    int                  failures = 0;
    int                  n_tests = 0;
    ext_bus_if u_ext_bus_if (.sys_clk_i, .rst_b_i, .req_valid_i, .req_i,
        .req_ready_o, .resp_o, .gate_wr_i, .gate_val_i,
        .external_access_select_n_i, .latch_pulse_gate_o, .p2_latch_i,
        .p0_latch_load_o, .p0_latch_data_o, .p0_i, .pins_o);
    ext_mem_model u_ext_mem_model (.sys_clk_i, .pins_i(pins_o),
        .bus_o(p0_i), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic run(input ext_bus_pkg::access_e k, input logic w,
        input logic [15:0] a, input logic [7:0] d, input logic sel_n);
        int n;
        n = 0;
        seen = 5'h00;
        @(posedge sys_clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{kind: k, wide: w, addr: a, wdata: d};
        external_access_select_n_i <= sel_n;
        do @(posedge sys_clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do begin
            @(negedge sys_clk_i);
            seen = seen | {pins_o.ale, p0_latch_load_o,
                ~pins_o.program_store_strobe_n, ~pins_o.rd_n, ~pins_o.wr_n};
            n++;
        end while (resp_o.done !== 1'b1 && n < 12);
        chk(32'(resp_o.done), 32'h0000_0001);
        chk(32'(p0_latch_data_o), 32'h0000_00FF);
    endtask
    task automatic set_gate(input logic v);
        @(posedge sys_clk_i);
        gate_wr_i <= 1'b1;
        gate_val_i <= v;
        @(posedge sys_clk_i);
        gate_wr_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(32'(latch_pulse_gate_o), 32'(v));
    endtask
    task automatic t_reset();
        chk(32'(pins_o), 32'(ext_bus_pkg::PINS_RST));
        chk(32'(latch_pulse_gate_o), 32'h0000_0001);
    endtask
    task automatic t_read();
        for (int w = 0; w < 2; w++) begin
            run(ext_bus_pkg::ACC_DREAD, w[0], 16'hA55A, 8'h00, 1'b1);
            chk(32'(seen), 32'h0000_001A);
            chk({24'h0, resp_o.rdata},
                {24'h0, 8'h5A ^ ~(w[0] ? 8'hA5 : 8'hC3)});
        end
    endtask
    task automatic t_write();
        for (int w = 0; w < 2; w++) begin
            run(ext_bus_pkg::ACC_DWRITE, w[0], 16'hBEEF, 8'h69, 1'b1);
            chk(32'(seen), 32'h0000_0019);
            chk(32'(wr_addr), w ? 32'h0000_BEEF : 32'h0000_C3EF);
            chk(32'(wr_data), 32'h0000_0069);
        end
    endtask
    task automatic t_fetch();
        logic [15:0] a [3] = '{16'h3FFF, 16'h4000, 16'h0123};
        for (int i = 0; i < 3; i++) begin
            run(ext_bus_pkg::ACC_FETCH, 1'b0, a[i], 8'h00, i != 2);
            chk(32'(seen), i ? 32'h0000_001C : 32'h0000_0010);
            chk(32'(resp_o.external), 32'(i != 0));
            if (i != 0) begin
                chk({24'h0, resp_o.rdata},
                    {24'h0, a[i][7:0] ^ ~a[i][15:8]});
            end
        end
    endtask
    task automatic t_gate();
        set_gate(1'b0);
        run(ext_bus_pkg::ACC_FETCH, 1'b1, 16'h0200, 8'h00, 1'b1);
        chk(32'(seen), 32'h0000_0000);
        run(ext_bus_pkg::ACC_DREAD, 1'b1, 16'h0300, 8'h00, 1'b1);
        chk(32'(seen), 32'h0000_001A);
        run(ext_bus_pkg::ACC_FETCH, 1'b1, 16'h0200, 8'h00, 1'b0);
        chk(32'(seen), 32'h0000_001C);
        set_gate(1'b1);
    endtask
    initial begin
        rst_b_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        gate_wr_i = 1'b0;
        gate_val_i = 1'b1;
        external_access_select_n_i = 1'b1;
        p2_latch_i = 8'hC3;
        repeat (10) @(posedge sys_clk_i);
        t_reset();
        rst_b_i <= 1'b1;
        t_read();
        t_write();
        t_fetch();
        t_gate();
        complete_run();
    end
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        failures++;
        complete_run();
    end
endmodule // tb_top
